// File: core/cmx_exec_core.sv
// Execution core for byte/word transfer, exchange, set/clear, store-with-flags and byte add.
// Assumes decoded requests, combinational data memory read and a separate fetch unit.
`default_nettype none

module cmx_exec_core #(
    parameter logic [19:0] FLASH_TOP = 20'h03fff
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Decoded instruction issue
    input wire logic req_valid,
    output logic req_ready,
    input wire cmx_pkg::cmx_req_t req,
    output logic [2:0] req_len,
    // Fetch context
    input wire logic fetch_from_ram,
    input wire logic [15:0] sp,
    // Data memory
    output cmx_pkg::cmx_mem_t mem,
    input wire logic [15:0] mem_rdata,
    // Status
    output logic done,
    output logic irq_hold,
    output cmx_pkg::cmx_gpr_t gpr,
    output logic [7:0] program_status_word,
    output logic [3:0] extension_segment_register
);
    import cmx_pkg::*;

    if (FLASH_TOP >= SADDR_LO) begin : g_bad_flash
        $error("FLASH_TOP overlaps the short direct window");
    end

    typedef enum logic {ST_IDLE, ST_EXEC} cmx_state_t;

    cmx_state_t state_q;
    cmx_req_t ins_q;
    logic [19:0] ea_q;
    logic [CNT_W-1:0] cnt_q;
    logic first_q, rd_en_q, wr_en_q;
    logic [15:0] rd_q;
    logic [7:0] gpr_q [8];
    logic [7:0] stat_q;
    logic [3:0] seg_q;

    // ==========================================================
    // Effective address of the incoming request
    wire [15:0] hl = {gpr_q[R_H], gpr_q[R_L]};
    wire [15:0] de = {gpr_q[R_D], gpr_q[R_E]};
    wire [15:0] bc = {gpr_q[R_B], gpr_q[R_C]};
    wire [15:0] d8 = {8'h00, req.disp8};
    logic [15:0] off16;

    always_comb begin
        unique case (req.mode)
            AM_ABS: off16 = req.imm16;
            AM_DE: off16 = de;
            AM_HL: off16 = hl;
            AM_DE_D: off16 = de + d8;
            AM_HL_D: off16 = hl + d8;
            AM_SP_D: off16 = sp + d8;
            AM_B_W: off16 = req.imm16 + {8'h00, gpr_q[R_B]};
            AM_C_W: off16 = req.imm16 + {8'h00, gpr_q[R_C]};
            AM_BC_W: off16 = req.imm16 + bc;
            AM_HL_B: off16 = hl + {8'h00, gpr_q[R_B]};
            AM_HL_C: off16 = hl + {8'h00, gpr_q[R_C]};
            default: off16 = 16'h0000;
        endcase
    end

    // Short direct offsets below the wrap point land in the top page
    wire [19:0] saddr_ea = (req.disp8 < SADDR_WRAP) ? {SFR_PAGE, req.disp8} : {SADDR_PAGE, req.disp8}; // RQ18
    wire [3:0] bank = req.seg ? seg_q : NOSEG_BANK; // RQ4
    wire [19:0] ea_raw = (req.mode == AM_SADDR) ? saddr_ea :
                         (req.mode == AM_SFR) ? {SFR_PAGE, req.disp8} : {bank, off16};
    wire is_mem = (req.mode != AM_REG) && (req.mode != AM_IMM);
    wire word_op = (req.op == OP_LD16) || (req.op == OP_ST16);
    wire [19:0] ea_n = word_op ? {ea_raw[19:1], 1'b0} : ea_raw; // RQ17
    wire reads_n = is_mem && (req.op inside {OP_LD8, OP_SWAP8, OP_ADD8, OP_LD16, OP_LDSEG}); // RQ8
    wire writes_n = is_mem && ((req.op inside {OP_ST8, OP_SWAP8, OP_ST16, OP_STF, OP_ONE8, OP_CLR8}) ||
                               (req.op == OP_ADD8 && req.dst_mem));
    // Only byte and word loads and byte add pay the flash penalty; exchange, segment load and stores never do
    wire flash_n = reads_n && (ea_n <= FLASH_TOP) && (req.op inside {OP_LD8, OP_ADD8, OP_LD16}); // RQ2

    // ==========================================================
    // Clock count and instruction length
    function automatic logic [CNT_W-1:0] base_cycles(input cmx_req_t r, input logic fl);
        logic [CNT_W-1:0] s;
        s = r.seg ? CYC_SEG : '0;
        unique case (r.op)
            OP_LD8: base_cycles = fl ? CYC_FLASH_B + s : CYC_ONE + s; // RQ1 RQ2 RQ14
            OP_ST8, OP_ONE8, OP_CLR8, OP_STF: base_cycles = CYC_ONE + s; // RQ5 RQ6
            OP_SWAP8: base_cycles = (r.mode == AM_REG) ? CYC_ONE : CYC_SWAP + s; // RQ7 RQ15
            OP_ADD8: base_cycles = r.dst_mem ? CYC_RMW : (fl ? CYC_FLASH_B + s : CYC_ONE + s); // RQ10
            OP_LD16: base_cycles = fl ? CYC_FLASH_W + s : CYC_WORD + s; // RQ11 RQ13
            OP_ST16, OP_SWAP16, OP_ONE16, OP_CLR16: base_cycles = CYC_WORD + s; // RQ12
            OP_LDSTAT: base_cycles = CYC_STAT;
            OP_LDSEG: base_cycles = CYC_ONE;
            // Undefined operation codes still retire in one clock
            default: base_cycles = CYC_ONE;
        endcase
    endfunction

    function automatic logic [2:0] inst_len(input cmx_req_t r);
        logic [2:0] m;
        logic [2:0] x;
        unique case (r.mode)
            AM_REG, AM_DE, AM_HL: m = 3'h1;
            AM_ABS, AM_B_W, AM_C_W, AM_BC_W: m = 3'h3;
            default: m = 3'h2;
        endcase
        unique case (r.op)
            OP_ST8: x = r.use_imm ? 3'h1 : 3'h0;
            OP_SWAP8: x = (r.mode == AM_REG) ? ((r.src_r == R_X) ? 3'h0 : 3'h1) :
                         ((r.mode inside {AM_HL_B, AM_HL_C}) ? 3'h0 : 3'h1); // RQ7
            OP_ADD8: x = (r.mode == AM_REG || r.dst_mem) ? 3'h1 : 3'h0;
            OP_STF, OP_LDSTAT: x = 3'h1;
            OP_LDSEG: x = (r.mode == AM_IMM) ? 3'h0 : 3'h1;
            OP_LD16: x = (r.mode == AM_IMM) ? 3'h1 : 3'h0;
            OP_ST16: x = r.use_imm ? 3'h2 : 3'h0;
            default: x = 3'h0;
        endcase
        inst_len = m + x + {2'b00, r.seg}; // RQ4
    endfunction

    wire [CNT_W-1:0] base_n = base_cycles(req, flash_n);
    // Worst case of a RAM-resident program is taken, so timing stays deterministic
    wire [CNT_W-1:0] total_n = fetch_from_ram ? CNT_W'(base_n * RAMF_MUL + RAMF_ADD) : base_n; // RQ3

    assign req_len = inst_len(req);
    assign req_ready = (state_q == ST_IDLE);
    wire accept = req_valid && req_ready;
    wire last = (state_q == ST_EXEC) && (cnt_q == '0);

    // ==========================================================
    // Sequencer
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            cnt_q <= '0;
            first_q <= 1'b0;
        end else if (accept) begin
            state_q <= ST_EXEC;
            cnt_q <= total_n - CYC_ONE;
            first_q <= 1'b1;
        end else if (state_q == ST_EXEC) begin
            state_q <= last ? ST_IDLE : ST_EXEC;
            cnt_q <= cnt_q - CYC_ONE;
            first_q <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (accept) begin
            ins_q <= req;
            ea_q <= ea_n;
            rd_en_q <= reads_n;
            wr_en_q <= writes_n;
        end
        if (first_q) begin
            rd_q <= mem_rdata;
        end
    end

    // ==========================================================
    // Datapath
    wire [7:0] acc = gpr_q[R_A];
    wire [7:0] xr = gpr_q[R_X];
    wire [7:0] rd_byte = first_q ? mem_rdata[7:0] : rd_q[7:0];
    wire [15:0] rd_word = first_q ? mem_rdata : rd_q;
    wire [7:0] src_b = ins_q.use_imm ? ins_q.imm8 : ((ins_q.mode == AM_REG) ? gpr_q[ins_q.src_r] : rd_byte);
    wire [7:0] st_b = ins_q.use_imm ? ins_q.imm8 : gpr_q[ins_q.src_r];
    wire [7:0] add_a = ins_q.dst_mem ? rd_byte : gpr_q[ins_q.dst_r];
    wire [15:0] tgt_pair = {gpr_q[{ins_q.rp, 1'b1}], gpr_q[{ins_q.rp, 1'b0}]};
    wire [15:0] src_pair = {gpr_q[{ins_q.src_r[1:0], 1'b1}], gpr_q[{ins_q.src_r[1:0], 1'b0}]};
    wire [15:0] ax = {acc, xr};
    wire [7:0] sum;
    wire add_z, add_aux, add_carry;

    cmx_add8 u_add (
        .a(add_a),
        .b(src_b),
        .sum(sum),
        .zero(add_z),
        .aux(add_aux),
        .carry(add_carry)
    );

    logic [7:0] wen;
    logic [7:0] wval [8];
    logic [7:0] stat_d;
    logic [3:0] seg_d;
    logic [15:0] mem_wd;

    always_comb begin
        wen = 8'h00;
        for (int i = 0; i < 8; i++) begin
            wval[i] = 8'h00;
        end
        stat_d = stat_q;
        seg_d = seg_q;
        mem_wd = 16'h0000;
        if (last) begin
            unique case (ins_q.op)
                OP_LD8: begin
                    wen[ins_q.dst_r] = 1'b1;
                    wval[ins_q.dst_r] = src_b; // RQ14
                end
                OP_ST8: mem_wd = {8'h00, st_b};
                OP_SWAP8: begin
                    wen[R_A] = 1'b1;
                    wval[R_A] = (ins_q.mode == AM_REG) ? gpr_q[ins_q.src_r] : rd_byte; // RQ7
                    if (ins_q.mode == AM_REG) begin
                        wen[ins_q.src_r] = 1'b1;
                        wval[ins_q.src_r] = acc;
                    end
                    mem_wd = {8'h00, acc}; // RQ8 RQ15
                end
                OP_ONE8, OP_CLR8: begin
                    mem_wd = {8'h00, (ins_q.op == OP_ONE8) ? BYTE_ONE : BYTE_ZERO};
                    if (ins_q.mode == AM_REG) begin
                        wen[ins_q.dst_r] = 1'b1;
                        wval[ins_q.dst_r] = mem_wd[7:0]; // RQ5
                    end
                end
                OP_STF: begin
                    mem_wd = {8'h00, xr};
                    stat_d[STAT_ZERO_BIT] = (xr == 8'h00); // RQ6
                    stat_d[STAT_CARRY_BIT] = (xr == 8'h00) || (acc == 8'h00);
                end
                OP_ADD8: begin
                    mem_wd = {8'h00, sum}; // RQ10
                    if (!ins_q.dst_mem) begin
                        wen[ins_q.dst_r] = 1'b1;
                        wval[ins_q.dst_r] = sum; // RQ9
                    end
                    stat_d[STAT_ZERO_BIT] = add_z;
                    stat_d[STAT_AUX_BIT] = add_aux;
                    stat_d[STAT_CARRY_BIT] = add_carry;
                end
                OP_LD16, OP_ONE16, OP_CLR16, OP_SWAP16: begin
                    wen[{ins_q.rp, 1'b1}] = 1'b1;
                    wen[{ins_q.rp, 1'b0}] = 1'b1;
                    {wval[{ins_q.rp, 1'b1}], wval[{ins_q.rp, 1'b0}]} =
                        (ins_q.op == OP_ONE16) ? WORD_ONE : (ins_q.op == OP_CLR16) ? WORD_ZERO :
                        (ins_q.op == OP_SWAP16) ? ax : ins_q.use_imm ? ins_q.imm16 :
                        (ins_q.mode == AM_REG) ? src_pair : rd_word; // RQ11 RQ13
                    if (ins_q.op == OP_SWAP16) begin
                        wen[R_A] = 1'b1;
                        wen[R_X] = 1'b1;
                        {wval[R_A], wval[R_X]} = tgt_pair;
                    end
                end
                OP_ST16: mem_wd = ins_q.use_imm ? ins_q.imm16 : tgt_pair; // RQ12
                OP_LDSTAT: stat_d = ins_q.use_imm ? ins_q.imm8 : acc; // RQ19
                OP_LDSEG: seg_d = src_b[3:0];
            endcase
        end
    end

    for (genvar i = 0; i < 8; i++) begin : g_gpr
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                gpr_q[i] <= GPR_RST;
            end else if (wen[i]) begin
                gpr_q[i] <= wval[i];
            end
        end
        assign gpr[i] = gpr_q[i];
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            stat_q <= STAT_RST;
            seg_q <= SEG_RST;
        end else begin
            stat_q <= stat_d;
            seg_q <= seg_d;
        end
    end

    // ==========================================================
    // Outputs
    assign mem.req = (state_q == ST_EXEC) && ((first_q && rd_en_q) || (last && wr_en_q));
    assign mem.we = last && wr_en_q;
    assign mem.word = (ins_q.op == OP_LD16) || (ins_q.op == OP_ST16);
    assign mem.addr = ea_q;
    assign mem.wdata = mem_wd;
    assign done = last;
    // Keeps interrupt and DMA grant off while a segment-prefixed instruction runs
    assign irq_hold = (state_q == ST_EXEC) && ins_q.seg; // RQ16
    assign program_status_word = stat_q;
    assign extension_segment_register = seg_q;

    // ==========================================================
    // Checks
    wire ld_abs = accept && req.op == OP_LD8 && req.mode == AM_ABS && !fetch_from_ram;

    ram_load_time_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ1
        ld_abs && !flash_n && !req.seg |-> ##1 done) else $error("RAM byte load not 1 clock");
    flash_load_time_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ2
        ld_abs && flash_n && req.seg |-> !done [*5] ##1 done) else $error("segmented flash load not 5 clocks");
    ram_fetch_time_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ3
        accept && fetch_from_ram && base_n == CYC_ONE |-> ##10 done) else $error("RAM fetch count wrong");
    swap_mem_time_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ7
        accept && req.op == OP_SWAP8 && is_mem && !req.seg && !fetch_from_ram |-> ##2 done)
        else $error("memory exchange not 2 clocks");
    set_one_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ5
        done && ins_q.op == OP_ONE8 && ins_q.mode == AM_REG |=> gpr_q[ins_q.dst_r] == BYTE_ONE && $stable(stat_q))
        else $error("set-one result wrong");
    store_flags_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ6
        done && ins_q.op == OP_STF |=> stat_q[STAT_ZERO_BIT] == ($past(xr) == 8'h00) &&
        stat_q[STAT_CARRY_BIT] == ($past(xr) == 8'h00 || $past(acc) == 8'h00) &&
        stat_q[STAT_AUX_BIT] == $past(stat_q[STAT_AUX_BIT])) else $error("store-with-flags flags wrong");
    add_result_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ9
        done && ins_q.op == OP_ADD8 && !ins_q.dst_mem |=>
        {stat_q[STAT_CARRY_BIT], gpr_q[ins_q.dst_r]} == {1'b0, $past(add_a)} + {1'b0, $past(src_b)})
        else $error("add sum or carry wrong");
    word_even_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ17
        mem.req && mem.word |-> mem.addr[0] == 1'b0) else $error("odd word address");
    saddr_window_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ18
        mem.req && ins_q.mode == AM_SADDR |-> mem.addr >= SADDR_LO && mem.addr <= SADDR_HI)
        else $error("short direct outside window");
    prefix_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ16
        accept && req.seg |=> irq_hold throughout (##[0:31] done)) else $error("prefix hold dropped");
    flags_kept_a: assert property (@(posedge clk) disable iff (sys_rst) // RQ19
        done && (ins_q.op inside {OP_LD8, OP_ST8, OP_SWAP8, OP_CLR8, OP_LD16, OP_SWAP16}) |=> $stable(stat_q))
        else $error("transfer changed flags");
endmodule

`default_nettype wire

// File: core/cmx_pkg.sv
// Shared types and constants for the move/exchange/add execution core.
// Assumes a decoder upstream that hands over one decoded instruction at a time.
//
// Operation
// [RQ1] RAM, SFR or no-data access uses primary count
// [RQ2] Flash byte loads take 4, or 5 segmented
// [RQ3] RAM fetch stretches count to four-fold plus 6
// [RQ4] Segmented forms: one byte, one clock more
// [RQ5] Set-one/clear write 01H/00H, flags untouched
// [RQ6] Store-with-flags writes X, sets zero and carry
// [RQ7] Byte exchange swaps A, memory forms 2 or 3
// [RQ8] Exchange covers all memory modes, no flash count
// [RQ9] Add stores binary sum, sets all three flags
// [RQ10] Immediate add to saddr is 2-clock read-modify-write
// [RQ11] Word load to AX: 2/5, segmented 3/6
// [RQ12] Word store takes 2, segmented 3
// [RQ13] BC/DE/HL load from abs or saddr
// [RQ14] X/B/C load abs or saddr, segment from saddr
// [RQ15] Exchange with HL+B/HL+C takes 2 or 3
// [RQ16] No interrupt or DMA inside prefixed instruction
// [RQ17] Word accesses force address bit 0 low
// [RQ18] Short direct reaches only FFE20H to FFF1FH
// [RQ19] Transfers keep flags, status word write replaces all
// [RQ20] Aux carry is bit-3 carry, zero on zero
`default_nettype none

package cmx_pkg;

    // ==========================================================
    // Register file indices and status word layout
    localparam logic [2:0] R_X = 3'h0;
    localparam logic [2:0] R_A = 3'h1;
    localparam logic [2:0] R_C = 3'h2;
    localparam logic [2:0] R_B = 3'h3;
    localparam logic [2:0] R_E = 3'h4;
    localparam logic [2:0] R_D = 3'h5;
    localparam logic [2:0] R_L = 3'h6;
    localparam logic [2:0] R_H = 3'h7;
    localparam int STAT_ZERO_BIT = 6;
    localparam int STAT_AUX_BIT = 4;
    localparam int STAT_CARRY_BIT = 0;

    localparam logic [7:0] GPR_RST = 8'h00;
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [3:0] SEG_RST = 4'h0;

    // ==========================================================
    // Address map
    localparam logic [19:0] SADDR_LO = 20'hffe20;
    localparam logic [19:0] SADDR_HI = 20'hfff1f;
    localparam logic [7:0] SADDR_WRAP = 8'h20;
    localparam logic [11:0] SADDR_PAGE = 12'hffe;
    localparam logic [11:0] SFR_PAGE = 12'hfff;
    localparam logic [3:0] NOSEG_BANK = 4'hf;

    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [15:0] WORD_ONE = 16'h0001;
    localparam logic [15:0] WORD_ZERO = 16'h0000;

    // ==========================================================
    // Clock counts
    localparam int CNT_W = 6;
    localparam logic [CNT_W-1:0] CYC_ONE = 6'h01;
    localparam logic [CNT_W-1:0] CYC_SEG = 6'h01;
    localparam logic [CNT_W-1:0] CYC_SWAP = 6'h02;
    localparam logic [CNT_W-1:0] CYC_RMW = 6'h02;
    localparam logic [CNT_W-1:0] CYC_WORD = 6'h02;
    localparam logic [CNT_W-1:0] CYC_STAT = 6'h03;
    localparam logic [CNT_W-1:0] CYC_FLASH_B = 6'h04;
    localparam logic [CNT_W-1:0] CYC_FLASH_W = 6'h05;
    localparam logic [CNT_W-1:0] RAMF_MUL = 6'h04;
    localparam logic [CNT_W-1:0] RAMF_ADD = 6'h06;

    // ==========================================================
    // Decoded operations and operand modes
    typedef enum logic [3:0] {
        OP_LD8, OP_ST8, OP_SWAP8, OP_ONE8, OP_CLR8, OP_STF, OP_ADD8,
        OP_LD16, OP_ST16, OP_SWAP16, OP_ONE16, OP_CLR16, OP_LDSTAT, OP_LDSEG
    } cmx_op_t;

    typedef enum logic [3:0] {
        AM_REG, AM_IMM, AM_ABS, AM_SADDR, AM_SFR, AM_DE, AM_HL, AM_DE_D,
        AM_HL_D, AM_SP_D, AM_B_W, AM_C_W, AM_BC_W, AM_HL_B, AM_HL_C
    } cmx_mode_t;

    typedef struct packed {
        cmx_op_t op;
        cmx_mode_t mode;
        logic seg;
        logic dst_mem;
        logic use_imm;
        logic [2:0] dst_r;
        logic [2:0] src_r;
        logic [1:0] rp;
        logic [7:0] imm8;
        logic [15:0] imm16;
        logic [7:0] disp8;
    } cmx_req_t;

    typedef struct packed {
        logic req;
        logic we;
        logic word;
        logic [19:0] addr;
        logic [15:0] wdata;
    } cmx_mem_t;

    typedef logic [7:0][7:0] cmx_gpr_t;

endpackage

`default_nettype wire

// File: core/cmx_add8.sv
// 8-bit binary adder with zero, nibble-carry and carry outputs.
// Pure combinational; the caller decides which flags are kept.
`default_nettype none

module cmx_add8 (
    // Operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    // Result
    output logic [7:0] sum,
    output logic zero,
    output logic aux,
    output logic carry
);
    wire [8:0] full = {1'b0, a} + {1'b0, b};
    wire [4:0] low = {1'b0, a[3:0]} + {1'b0, b[3:0]};

    assign sum = full[7:0];
    assign carry = full[8];
    assign aux = low[4]; // RQ20
    assign zero = (full[7:0] == 8'h00); // RQ20
endmodule

`default_nettype wire

// File: sim/cpu_move_and_add_execution_test.sv
// Self-checking bench for the move/exchange/add execution core.
// Assumes cmx_pkg is compiled first; the bench answers every read combinationally.
`default_nettype none

module cpu_move_and_add_execution_test;
    timeunit 1ns;
    timeprecision 100ps;
    import cmx_pkg::*;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic req_valid = 1'b0;
    logic fetch_from_ram = 1'b0;
    logic [15:0] mem_rdata = 16'h0000;
    cmx_req_t req = '0;
    logic req_ready, done, irq_hold;
    logic [2:0] req_len;
    cmx_mem_t mem;
    cmx_gpr_t gpr, m_gpr;
    logic [7:0] stat_word, m_stat, a0;
    logic [3:0] seg_reg;
    logic [19:0] cap_addr;
    logic [15:0] cap_wdata;
    logic [31:0] lf = 32'h89c412b8;
    logic [8:0] s9;
    int errors = 0;
    int cmp_count = 0;

    cmx_exec_core u_cmx_exec_core (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid),
        .req_ready(req_ready), .req(req), .req_len(req_len), .fetch_from_ram(fetch_from_ram),
        .sp(16'h0100), .mem(mem), .mem_rdata(mem_rdata), .done(done), .irq_hold(irq_hold),
        .gpr(gpr), .program_status_word(stat_word), .extension_segment_register(seg_reg));

    initial begin
        forever #2.5 clk = ~clk;
    end

    // ==========================================================
    // Helpers
    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Offset sits in every immediate field: the decoder may take it from any of them
    function automatic cmx_req_t mk(input cmx_op_t op, input cmx_mode_t md, input logic sg,
                                    input logic dm, input logic [2:0] dr, input logic [15:0] v);
        cmx_req_t r;
        r = '0;
        r.op = op;
        r.mode = md;
        r.seg = sg;
        r.dst_mem = dm;
        r.use_imm = (md == AM_IMM) | dm;
        r.dst_r = dr;
        r.src_r = R_X;
        r.rp = dr[2:1];
        r.imm8 = v[7:0];
        r.imm16 = v;
        r.disp8 = v[7:0];
        return r;
    endfunction

    // Binary add: bit-3 carry to the aux flag, bit-7 carry to the carry flag
    function automatic logic [8:0] add_flags(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        m_stat[STAT_ZERO_BIT] = (s[7:0] == 8'h00);
        m_stat[STAT_AUX_BIT] = ({1'b0, a[3:0]} + {1'b0, b[3:0]}) > 5'h0f;
        m_stat[STAT_CARRY_BIT] = s[8];
        return s;
    endfunction

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic results();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Issue one instruction, count cycles to done, then compare state with the model
    task automatic run(input cmx_req_t r, input logic ram, input int n, input int len);
        int k;
        logic irq_seen;
        irq_seen = 1'b0;
        cap_addr = '1;
        req = r;
        req_valid = 1'b1;
        fetch_from_ram = ram;
        #1;
        chk("req_len", len, req_len);
        chk("req_ready", 1'b1, req_ready);
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        k = 1;
        while (done !== 1'b1) begin
            if (mem.req === 1'b1 && cap_addr === '1) cap_addr = mem.addr;
            if (mem.we === 1'b1 && mem.req === 1'b1) cap_wdata = mem.wdata;
            if (irq_hold === 1'b1) irq_seen = 1'b1;
            if (k > 60) begin
                errors++;
                results();
            end
            @(posedge clk);
            #1;
            k++;
        end
        if (mem.req === 1'b1 && cap_addr === '1) cap_addr = mem.addr;
        if (mem.we === 1'b1 && mem.req === 1'b1) cap_wdata = mem.wdata;
        if (irq_hold === 1'b1) irq_seen = 1'b1;
        chk("cycles", n, k);
        chk("irq_hold", r.seg, irq_seen);
        @(posedge clk);
        #1;
        chk("gpr", m_gpr, gpr);
        chk("stat", m_stat, stat_word);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        m_gpr = '0;
        m_stat = STAT_RST;
        repeat (6) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        chk("gpr_rst", '0, gpr);
        chk("stat_rst", STAT_RST, stat_word);
        chk("seg_rst", SEG_RST, seg_reg);
        foreach (m_gpr[i]) begin
            if (i < 4) begin
                m_gpr[i] = BYTE_ONE;
                run(mk(OP_ONE8, AM_REG, 1'b0, 1'b0, 3'(i), 16'h0), 1'b0, 1, 1);
            end
        end
        m_gpr[R_B] = BYTE_ZERO;
        run(mk(OP_CLR8, AM_REG, 1'b0, 1'b0, R_B, 16'h0), 1'b1, 10, 1);
        for (int i = 0; i < 10; i++) begin
            lf = nxt(lf);
            if (i == 9) lf[7:0] = 8'h00 - m_gpr[R_A];
            s9 = add_flags(m_gpr[R_A], lf[7:0]);
            m_gpr[R_A] = s9[7:0];
            run(mk(OP_ADD8, AM_IMM, 1'b0, 1'b0, R_A, {8'h00, lf[7:0]}), 1'b0, 1, 2);
        end
        foreach (m_gpr[i]) begin
            if (i < 4) begin
                lf = nxt(lf);
                mem_rdata = lf[15:0];
                m_gpr[i] = lf[7:0];
                run(mk(OP_LD8, AM_ABS, 1'b0, 1'b0, 3'(i), 16'h2468), 1'b0, 1, 3);
                chk("addr", {NOSEG_BANK, 16'h2468}, cap_addr);
            end
        end
        m_gpr[R_A] = mem_rdata[7:0] ^ 8'h5a;
        mem_rdata = {8'h00, m_gpr[R_A]};
        run(mk(OP_LD8, AM_ABS, 1'b1, 1'b0, R_A, 16'h0100), 1'b0, 5, 4);
        chk("addr_seg", {SEG_RST, 16'h0100}, cap_addr);
        run(mk(OP_LD8, AM_SADDR, 1'b0, 1'b0, R_A, 16'h0020), 1'b0, 1, 2);
        chk("saddr_lo", SADDR_LO, cap_addr);
        run(mk(OP_LD8, AM_SADDR, 1'b0, 1'b0, R_A, 16'h001f), 1'b0, 1, 2);
        chk("saddr_hi", SADDR_HI, cap_addr);
        for (int i = 0; i < 3; i++) begin
            lf = nxt(lf);
            mem_rdata = lf[15:0];
            a0 = m_gpr[R_A];
            m_gpr[R_A] = lf[7:0];
            if (i < 2) run(mk(OP_SWAP8, AM_ABS, i[0], 1'b0, R_A, 16'h3000), 1'b0, 2 + i, 4 + i);
            else run(mk(OP_SWAP8, AM_HL_B, 1'b0, 1'b0, R_A, 16'h0), 1'b0, 2, 2);
            chk("swap_wr", a0, cap_wdata[7:0]);
        end
        lf = nxt(lf);
        mem_rdata = lf[15:0];
        s9 = add_flags(lf[7:0], 8'h30);
        run(mk(OP_ADD8, AM_SADDR, 1'b0, 1'b1, R_A, 16'h0030), 1'b0, 2, 3);
        chk("rmw_wr", s9[7:0], cap_wdata[7:0]);
        mem_rdata = 16'h9a3c;
        {m_gpr[R_A], m_gpr[R_X]} = mem_rdata;
        run(mk(OP_LD16, AM_ABS, 1'b0, 1'b0, R_X, 16'h1235), 1'b0, 2, 3);
        chk("word_addr", {NOSEG_BANK, 16'h1234}, cap_addr);
        run(mk(OP_LD16, AM_ABS, 1'b1, 1'b0, R_X, 16'h0200), 1'b0, 6, 4);
        mem_rdata = 16'h7e01;
        {m_gpr[R_B], m_gpr[R_C]} = mem_rdata;
        run(mk(OP_LD16, AM_ABS, 1'b1, 1'b0, R_C, 16'h0300), 1'b0, 6, 4);
        run(mk(OP_ST16, AM_ABS, 1'b0, 1'b0, R_X, 16'h4000), 1'b0, 2, 3);
        chk("st16_wr", {m_gpr[R_A], m_gpr[R_X]}, cap_wdata);
        chk("mem_word", 1'b1, mem.word);
        m_stat[STAT_ZERO_BIT] = (m_gpr[R_X] == 8'h00);
        m_stat[STAT_CARRY_BIT] = (m_gpr[R_X] == 8'h00) | (m_gpr[R_A] == 8'h00);
        run(mk(OP_STF, AM_HL_D, 1'b1, 1'b1, R_X, 16'h0004), 1'b0, 2, 4);
        chk("store_with_flags_wr", m_gpr[R_X], cap_wdata[7:0]);
        {m_gpr[R_A], m_gpr[R_X]} = WORD_ONE;
        run(mk(OP_ONE16, AM_REG, 1'b0, 1'b0, R_X, 16'h0), 1'b0, 2, 1);
        // Non-zero segment moves the segmented load out of the flash range
        mem_rdata = 16'h00a9;
        run(mk(OP_LDSEG, AM_SADDR, 1'b0, 1'b0, R_A, 16'h0040), 1'b0, 1, 3);
        chk("seg_reg", 4'h9, seg_reg);
        m_gpr[R_C] = mem_rdata[7:0];
        run(mk(OP_LD8, AM_ABS, 1'b1, 1'b0, R_C, 16'h0100), 1'b0, 2, 4);
        chk("addr_ext", {4'h9, 16'h0100}, cap_addr);
        lf = nxt(lf);
        m_stat = lf[7:0];
        run(mk(OP_LDSTAT, AM_IMM, 1'b0, 1'b0, R_A, {8'h00, lf[7:0]}), 1'b0, 3, 3);
        results();
    end
endmodule

`default_nettype wire
